//--- design/tap_port.sv
/*
 * test access port controller with instruction, bypass, id and a debug
 * request data register. assumes test pins arrive asynchronously and
 * the processor reset is handled outside this block.
 */
`timescale 1ns/1ps
module tap_port (
    // system
    input wire logic clk_sys,
    input wire logic sys_rst,
    // test pins
    input wire logic testClk,
    input wire logic testClkDriven,
    input wire logic modeSel,
    input wire logic dataIn,
    input wire logic testRstN,
    output logic dataOut,
    output logic dataOutEn,
    // debug side
    input wire logic [31:0] debugStatus,
    output logic [31:0] debugCommand,
    output logic debugUpdate,
    output logic [3:0] tapState
);
    tap_edge_if edges();

    tap_pin_sync sync (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .testClk(testClk),
        .testClkDriven(testClkDriven),
        .modeSel(modeSel),
        .dataIn(dataIn),
        .testRstN(testRstN),
        .edges(edges)
    );

    tap_port_pkg::tap_state_type state_reg, state_next;
    logic [3:0] irShift_reg, irShift_next;
    logic [3:0] ir_reg, ir_next;
    logic [31:0] drShift_reg, drShift_next;
    logic [31:0] cmd_reg, cmd_next;
    logic upd_reg, upd_next;
    logic tdo_reg, tdo_next;
    logic tdoEn_reg, tdoEn_next;
    logic [4:0] powerOn_reg, powerOn_next;

    // ========================================
    // standard controller step on mode select
    function automatic tap_port_pkg::tap_state_type step(
        input tap_port_pkg::tap_state_type s,
        input logic m
    );
        case (s)
            tap_port_pkg::TEST_LOGIC_RESET: step = m ?
                tap_port_pkg::TEST_LOGIC_RESET : tap_port_pkg::RUN_TEST_IDLE;
            tap_port_pkg::RUN_TEST_IDLE: step = m ?
                tap_port_pkg::SELECT_DR : tap_port_pkg::RUN_TEST_IDLE;
            tap_port_pkg::SELECT_DR: step = m ?
                tap_port_pkg::SELECT_IR : tap_port_pkg::CAPTURE_DR;
            tap_port_pkg::CAPTURE_DR: step = m ?
                tap_port_pkg::EXIT1_DR : tap_port_pkg::SHIFT_DR;
            tap_port_pkg::SHIFT_DR: step = m ?
                tap_port_pkg::EXIT1_DR : tap_port_pkg::SHIFT_DR;
            tap_port_pkg::EXIT1_DR: step = m ?
                tap_port_pkg::UPDATE_DR : tap_port_pkg::PAUSE_DR;
            tap_port_pkg::PAUSE_DR: step = m ?
                tap_port_pkg::EXIT2_DR : tap_port_pkg::PAUSE_DR;
            tap_port_pkg::EXIT2_DR: step = m ?
                tap_port_pkg::UPDATE_DR : tap_port_pkg::SHIFT_DR;
            tap_port_pkg::UPDATE_DR: step = m ?
                tap_port_pkg::SELECT_DR : tap_port_pkg::RUN_TEST_IDLE;
            tap_port_pkg::SELECT_IR: step = m ?
                tap_port_pkg::TEST_LOGIC_RESET : tap_port_pkg::CAPTURE_IR;
            tap_port_pkg::CAPTURE_IR: step = m ?
                tap_port_pkg::EXIT1_IR : tap_port_pkg::SHIFT_IR;
            tap_port_pkg::SHIFT_IR: step = m ?
                tap_port_pkg::EXIT1_IR : tap_port_pkg::SHIFT_IR;
            tap_port_pkg::EXIT1_IR: step = m ?
                tap_port_pkg::UPDATE_IR : tap_port_pkg::PAUSE_IR;
            tap_port_pkg::PAUSE_IR: step = m ?
                tap_port_pkg::EXIT2_IR : tap_port_pkg::PAUSE_IR;
            tap_port_pkg::EXIT2_IR: step = m ?
                tap_port_pkg::UPDATE_IR : tap_port_pkg::SHIFT_IR;
            tap_port_pkg::UPDATE_IR: step = m ?
                tap_port_pkg::SELECT_DR : tap_port_pkg::RUN_TEST_IDLE;
            default: step = tap_port_pkg::TEST_LOGIC_RESET;
        endcase
    endfunction

    // ========================================
    // edge gating: edges are refused during the power-on hold and while
    // the test reset is low, so a half-seen edge cannot move the machine
    logic holding, inReset;

    assign holding = powerOn_reg != tap_port_pkg::HOLD_CYCLES;
    assign inReset = !edges.testRstN || holding;

    // ========================================
    // decoders shared by the shift and output logic
    function automatic logic in_shift(
        input tap_port_pkg::tap_state_type s
    );
        return s == tap_port_pkg::SHIFT_IR || s == tap_port_pkg::SHIFT_DR;
    endfunction

    // id and debug instructions select the long register; every other
    // code, bypass included, shifts through a single bit
    function automatic logic long_dr(input logic [3:0] code);
        return code == tap_port_pkg::IR_IDCODE ||
            code == tap_port_pkg::IR_DEBUG_REQ;
    endfunction

    // ========================================
    // controller state and power-on hold
    always_comb begin
        state_next = state_reg;
        powerOn_next = powerOn_reg;
        if (holding) begin
            powerOn_next = powerOn_reg + 5'h01;
        end
        if (inReset) begin
            state_next = tap_port_pkg::TEST_LOGIC_RESET;
        end else if (edges.rise) begin
            state_next = step(state_reg, edges.modeSel);
        end
    end

    // sys_rst is only power-up init; a processor reset never reaches
    // this logic, so a debugger keeps its session across it
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_reg <= tap_port_pkg::TEST_LOGIC_RESET;
            powerOn_reg <= 5'h00;
        end else begin
            state_reg <= state_next;
            powerOn_reg <= powerOn_next;
        end
    end

    // ========================================
    // instruction register
    always_comb begin
        irShift_next = irShift_reg;
        ir_next = ir_reg;
        if (inReset) begin
            ir_next = tap_port_pkg::IR_RESET;
        end else if (edges.rise) begin
            case (state_reg)
                tap_port_pkg::TEST_LOGIC_RESET: begin
                    ir_next = tap_port_pkg::IR_IDCODE;
                end
                tap_port_pkg::CAPTURE_IR: begin
                    irShift_next = {2'h0, tap_port_pkg::IR_CAPTURE};
                end
                tap_port_pkg::SHIFT_IR: begin
                    irShift_next = {edges.dataIn, irShift_reg[3:1]};
                end
                tap_port_pkg::UPDATE_IR: begin
                    ir_next = irShift_reg;
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            irShift_reg <= 4'h0;
            ir_reg <= tap_port_pkg::IR_RESET;
        end else begin
            irShift_reg <= irShift_next;
            ir_reg <= ir_next;
        end
    end

    // ========================================
    // data registers and the debug command
    always_comb begin
        drShift_next = drShift_reg;
        cmd_next = cmd_reg;
        upd_next = 1'b0;
        if (!inReset && edges.rise) begin
            case (state_reg)
                tap_port_pkg::CAPTURE_DR: begin
                    case (ir_reg)
                        tap_port_pkg::IR_IDCODE:
                            drShift_next = tap_port_pkg::ID_VALUE;
                        tap_port_pkg::IR_DEBUG_REQ:
                            drShift_next = debugStatus;
                        default: drShift_next = tap_port_pkg::DR_RESET;
                    endcase
                end
                tap_port_pkg::SHIFT_DR: begin
                    if (long_dr(ir_reg)) begin
                        drShift_next = {edges.dataIn, drShift_reg[31:1]};
                    end else begin
                        drShift_next = {31'h0, edges.dataIn};
                    end
                end
                tap_port_pkg::UPDATE_DR: begin
                    if (ir_reg == tap_port_pkg::IR_DEBUG_REQ) begin
                        cmd_next = drShift_reg;
                        upd_next = 1'b1;
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            drShift_reg <= tap_port_pkg::DR_RESET;
            cmd_reg <= tap_port_pkg::DR_RESET;
            upd_reg <= 1'b0;
        end else begin
            drShift_reg <= drShift_next;
            cmd_reg <= cmd_next;
            upd_reg <= upd_next;
        end
    end

    // ========================================
    // serial output; apart from a test reset it moves on falling edges only, which gives the
    // host a full low phase before it samples on the next rise
    always_comb begin
        tdo_next = tdo_reg;
        tdoEn_next = tdoEn_reg;
        if (inReset) begin
            tdoEn_next = 1'b0;
            tdo_next = 1'b0;
        end else if (edges.fall) begin
            tdoEn_next = in_shift(state_reg);
            tdo_next = (state_reg == tap_port_pkg::SHIFT_IR) ?
                irShift_reg[0] : drShift_reg[0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            tdo_reg <= 1'b0;
            tdoEn_reg <= 1'b0;
        end else begin
            tdo_reg <= tdo_next;
            tdoEn_reg <= tdoEn_next;
        end
    end

    assign dataOut = tdo_reg;
    assign dataOutEn = tdoEn_reg;
    assign debugCommand = cmd_reg;
    assign debugUpdate = upd_reg;
    assign tapState = state_reg;
endmodule

//--- design/tap_port_pkg.sv
/*
 * constants and types for the serial test access port block.
 * assumes a single system clock that oversamples the test clock pins.
 */
// Overview of operation
// - Apart from the resets, only the edges of the test clock, found by oversampling, move the controller and the shift registers.
// - An undriven test clock pin is modelled as an idle low clock, so no edge is seen.
// - Mode select is taken on each rising test-clock edge and steers the controller.
// - Test data in is taken on each rising test-clock edge while shifting.
// - Test data out is driven only in Shift-IR or Shift-DR and changes on falling test-clock edges.
// - A low test reset puts the controller in Test-Logic-Reset independently of the chip reset.
// - The chip hardware reset resets the processor while the test port logic keeps its state.
package tap_port_pkg;
    // ========================================
    // controller states
    typedef enum logic [3:0] {
        TEST_LOGIC_RESET = 4'h0,
        RUN_TEST_IDLE = 4'h1,
        SELECT_DR = 4'h2,
        CAPTURE_DR = 4'h3,
        SHIFT_DR = 4'h4,
        EXIT1_DR = 4'h5,
        PAUSE_DR = 4'h6,
        EXIT2_DR = 4'h7,
        UPDATE_DR = 4'h8,
        SELECT_IR = 4'h9,
        CAPTURE_IR = 4'ha,
        SHIFT_IR = 4'hb,
        EXIT1_IR = 4'hc,
        PAUSE_IR = 4'hd,
        EXIT2_IR = 4'he,
        UPDATE_IR = 4'hf
    } tap_state_type;

    // ========================================
    // register widths and reset values
    localparam int IR_WIDTH = 4;
    localparam int DR_WIDTH = 32;
    localparam logic [3:0] IR_RESET = 4'hf;
    localparam logic [1:0] IR_CAPTURE = 2'h1;
    localparam logic [31:0] DR_RESET = 32'h0;
    // arbitrary identification value, carries no maker code
    localparam logic [31:0] ID_VALUE = 32'h00000001;
    localparam logic [3:0] IR_IDCODE = 4'h2;
    localparam logic [3:0] IR_BYPASS = 4'hf;
    localparam logic [3:0] IR_DEBUG_REQ = 4'h7;
    // power-on hold, in clk_sys cycles, before any edge is accepted
    localparam logic [4:0] HOLD_CYCLES = 5'h1f;
endpackage

//--- design/tap_edge_if.sv
/*
 * carries the sampled test clock edges and pins from the synchroniser
 * to the controller. assumes both sides run on clk_sys.
 */
`timescale 1ns/1ps
interface tap_edge_if;
    logic rise;
    logic fall;
    logic modeSel;
    logic dataIn;
    logic testRstN;
    modport source (output rise, output fall, output modeSel,
        output dataIn, output testRstN);
    modport sink (input rise, input fall, input modeSel, input dataIn,
        input testRstN);
endinterface

//--- design/tap_pin_sync.sv
/*
 * two-stage synchronisers for the test pins and edge detection of the
 * test clock. assumes the test clock is far slower than clk_sys.
 */
`timescale 1ns/1ps
module tap_pin_sync (
    // system
    input wire logic clk_sys,
    input wire logic sys_rst,
    // pins
    input wire logic testClk,
    input wire logic testClkDriven,
    input wire logic modeSel,
    input wire logic dataIn,
    input wire logic testRstN,
    // to controller
    tap_edge_if.source edges
);
    logic [3:0] stage1_reg, stage1_next;
    logic [3:0] stage2_reg, stage2_next;
    logic clkOld_reg, clkOld_next;
    logic clkPin;

    // ========================================
    // pin conditioning
    always_comb begin
        clkPin = testClk & testClkDriven;
        stage1_next = {clkPin, modeSel, dataIn, testRstN};
        stage2_next = stage1_reg;
        clkOld_next = stage2_reg[3];
    end

    // test reset must act without a clock edge, yet it passes the synchroniser
    // both ways; entry and release are each seen two cycles later
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            stage1_reg <= 4'h1;
            stage2_reg <= 4'h1;
            clkOld_reg <= 1'b0;
        end else begin
            stage1_reg <= stage1_next;
            stage2_reg <= stage2_next;
            clkOld_reg <= clkOld_next;
        end
    end

    assign edges.rise = stage2_reg[3] & ~clkOld_reg;
    assign edges.fall = ~stage2_reg[3] & clkOld_reg;
    assign edges.modeSel = stage2_reg[2];
    assign edges.dataIn = stage2_reg[1];
    assign edges.testRstN = stage2_reg[0];
endmodule

//--- test/tap_port_props.sv
/* checker on the test port pins and controller state.
   assumes test pins change well away from clk_sys edges. */
`timescale 1ns/1ps
module tap_port_props (
    // system
    input wire logic clk_sys, sys_rst,
    // test pins
    input wire logic testClk, testClkDriven, modeSel, testRstN,
    input wire logic dataOut, dataOutEn,
    // debug side
    input wire logic [31:0] debugCommand,
    input wire logic debugUpdate,
    input wire logic [3:0] tapState
);
    logic tcPrev;
    logic [3:0] riseAge, fallAge;
    logic [2:0] ones;
    wire logic tcEff = testClk & testClkDriven;
    wire logic up = tcEff && !tcPrev;
    wire logic dn = !tcEff && tcPrev;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // ========================================
    // pin edge ages, saturated so idle gaps never wrap
    always_ff @(posedge clk_sys) begin
        tcPrev <= tcEff;
        if (sys_rst) begin
            riseAge <= 4'hf;
            fallAge <= 4'hf;
            ones <= 3'h0;
        end else begin
            if (up) riseAge <= 4'h0;
            else if (riseAge != 4'hf) riseAge <= riseAge + 4'h1;
            if (dn) fallAge <= 4'h0;
            else if (fallAge != 4'hf) fallAge <= fallAge + 4'h1;
            if (up) ones <= !modeSel ? 3'h0 : ones + {2'h0, ones != 3'h7};
        end
    end
    // ========================================
    // properties
    a_five_ones: assert property (ones >= 3'h5 && riseAge >= 4'h6 |->
        tapState == tap_port_pkg::TEST_LOGIC_RESET) else $error("no reset");
    a_move_on_rise: assert property ($changed(tapState) && testRstN &&
        $past(testRstN, 4) |-> riseAge >= 4'h1 && riseAge <= 4'h5)
        else $error("state moved off a rise");
    a_out_on_fall: assert property ($changed(dataOut) && dataOutEn |->
        fallAge >= 4'h1 && fallAge <= 4'h6) else $error("out moved off fall");
    a_en_in_shift: assert property ($rose(dataOutEn) |->
        tapState inside {tap_port_pkg::SHIFT_DR, tap_port_pkg::SHIFT_IR})
        else $error("enable outside shift");
    a_en_quiet: assert property (tapState inside {tap_port_pkg::PAUSE_DR,
        tap_port_pkg::PAUSE_IR, tap_port_pkg::RUN_TEST_IDLE} |-> !dataOutEn)
        else $error("enable while parked");
    a_trst_state: assert property ((!testRstN)[*5] |->
        tapState == tap_port_pkg::TEST_LOGIC_RESET) else $error("trst state");
    a_trst_en: assert property ((!testRstN)[*5] |-> !dataOutEn)
        else $error("trst enable");
    a_undriven_still: assert property ((!testClkDriven && testRstN)[*8] |->
        $stable(tapState)) else $error("undriven clock moved state");
    a_update_pulse: assert property (debugUpdate |=> !debugUpdate)
        else $error("update pulse too long");
    a_cmd_load: assert property ($changed(debugCommand) |-> debugUpdate)
        else $error("command changed without update");
endmodule
bind tap_port tap_port_props i_props (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .testClk(testClk), .testClkDriven(testClkDriven), .modeSel(modeSel),
    .testRstN(testRstN), .dataOut(dataOut), .dataOutEn(dataOutEn),
    .debugCommand(debugCommand), .debugUpdate(debugUpdate),
    .tapState(tapState));

//--- test/jtag_host.sv
/* debugger model driving the test pins.
   assumes clk_sys at 4 ns: six cycles make a 24 ns half period. */
`timescale 1ns/1ps
module jtag_host (
    // system
    input wire logic clk_sys,
    // from the port
    input wire logic dataOut, dataOutEn,
    // test pins
    output logic testClk, testClkDriven, modeSel, dataIn, testRstN
);
    initial begin
        testClk = 1'b0;
        testClkDriven = 1'b1;
        modeSel = 1'b1;
        dataIn = 1'b0;
        testRstN = 1'b0;
    end
    // the test reset is let go together with the chip reset
    task automatic trst_end();
        testRstN = 1'b1;
    endtask
    task automatic half();
        repeat (6) @(posedge clk_sys);
        #1;
    endtask
    // ========================================
    // one clock period; the clock rests low between frames
    task automatic step(input logic m, input logic d,
        output logic [1:0] seen);
        modeSel = m;
        dataIn = d;
        half();
        testClk = 1'b1;
        seen = {dataOutEn, dataOut};
        half();
        testClk = 1'b0;
    endtask
    task automatic trst();
        testRstN = 1'b0;
        half();
        half();
        testRstN = 1'b1;
        half();
    endtask
    // a floating clock line toggles but must not count
    task automatic unplug(input int n);
        testClkDriven = 1'b0;
        repeat (n) begin
            testClk = 1'b1;
            half();
            testClk = 1'b0;
            half();
        end
        testClkDriven = 1'b1;
    endtask
endmodule

//--- test/tap_port_bench.sv
/* self-checking bench for the test access port.
   assumes the host model and the bound checker are compiled alongside. */
`timescale 1ns/1ps
module tap_port_bench;
    logic clk_sys, sys_rst, testClk, testClkDriven, modeSel, dataIn;
    logic testRstN, dataOut, dataOutEn, debugUpdate;
    logic [31:0] debugStatus, debugCommand, d, v, cmd;
    logic [3:0] tapState, es;
    logic [1:0] seen;
    int fails, total_checks, seed, k;
    // next state per current state, one nibble each, mode select low/high
    localparam logic [63:0] NEXT0 = 64'h1bddbba146644311;
    localparam logic [63:0] NEXT1 = 64'h2fefcc0287855920;
    tap_port i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .testClk(testClk),
        .testClkDriven(testClkDriven), .modeSel(modeSel), .dataIn(dataIn),
        .testRstN(testRstN), .dataOut(dataOut), .dataOutEn(dataOutEn),
        .debugStatus(debugStatus), .debugCommand(debugCommand),
        .debugUpdate(debugUpdate), .tapState(tapState));
    jtag_host i_host (.clk_sys(clk_sys), .dataOut(dataOut),
        .dataOutEn(dataOutEn), .testClk(testClk),
        .testClkDriven(testClkDriven), .modeSel(modeSel), .dataIn(dataIn),
        .testRstN(testRstN));
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    function automatic logic [3:0] nxt(input logic [3:0] s, input logic m);
        return 4'((m ? NEXT1 : NEXT0) >> {s, 2'h0});
    endfunction
    // ========================================
    // checking and transfer tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic tck(input logic m, input logic b);
        i_host.step(m, b, seen);
        es = nxt(es, m);
        check(tapState, es);
    endtask
    // shift lsb first, leave through update back to idle
    task automatic shift(input int n, input logic [31:0] din);
        d = 32'h0;
        for (int i = 0; i < n; i++) begin
            tck(i == n - 1, din[i]);
            d[i] = seen[0];
            check(seen[1], 1'b1);
        end
        tck(1'b1, 1'b0);
        tck(1'b0, 1'b0);
        check(dataOutEn, 1'b0);
    endtask
    task automatic ir(input logic [3:0] code);
        tck(1'b1, 1'b0);
        tck(1'b1, 1'b0);
        tck(1'b0, 1'b0);
        tck(1'b0, 1'b0);
        shift(4, {28'h0, code});
        check(d[1:0], tap_port_pkg::IR_CAPTURE);
    endtask
    task automatic dr(input int n, input logic [31:0] din);
        tck(1'b1, 1'b0);
        tck(1'b0, 1'b0);
        tck(1'b0, 1'b0);
        shift(n, din);
    endtask
    initial begin
        repeat (100000) @(posedge clk_sys);
        fails++;
        conclude();
    end
    // ========================================
    // main sequence
    initial begin
        seed = 24839;
        sys_rst = 1'b1;
        debugStatus = 32'h0;
        es = 4'h0;
        repeat (16) @(posedge clk_sys);
        #1;
        sys_rst = 1'b0;
        i_host.trst_end();
        repeat (40) @(posedge clk_sys);
        #1;
        check(tapState, 4'h0);
        for (k = 0; k < 6; k++) begin
            repeat (9) tck(1'($random(seed)), 1'($random(seed)));
            repeat (5) tck(1'b1, 1'b0);
            check(tapState, 4'h0);
        end
        $display("test walk done");
        tck(1'b0, 1'b0);
        ir(tap_port_pkg::IR_IDCODE);
        dr(32, $random(seed));
        check(d, tap_port_pkg::ID_VALUE);
        $display("test id done");
        for (k = 0; k < 2; k++) begin
            v = $random(seed);
            debugStatus = v;
            ir(tap_port_pkg::IR_DEBUG_REQ);
            cmd = $random(seed);
            dr(32, cmd);
            check(d, v);
            check(debugCommand, cmd);
        end
        // no reset is driven here; after 20 idle cycles the session stays
        repeat (20) @(posedge clk_sys);
        #1;
        check(debugCommand, cmd);
        check(tapState, es);
        $display("test debug done");
        // bypass, then an undefined code that must behave as bypass
        for (k = 0; k < 2; k++) begin
            ir(k == 0 ? tap_port_pkg::IR_BYPASS : 4'h5);
            v = $random(seed);
            dr(8, v);
            check(d[7:0], {v[6:0], 1'b0});
        end
        $display("test bypass done");
        tck(1'b1, 1'b0);
        tck(1'b1, 1'b0);
        tck(1'b0, 1'b0);
        tck(1'b0, 1'b1);
        i_host.trst();
        es = 4'h0;
        check(tapState, 4'h0);
        check(dataOutEn, 1'b0);
        $display("test reset done");
        tck(1'b0, 1'b0);
        i_host.unplug(4);
        check(tapState, es);
        $display("test undriven done");
        conclude();
    end
endmodule
